// file: common/serial_mode_controller_params.svh
// Constants of the serial operating-mode controller
`ifndef SERIAL_MODE_CONTROLLER_PARAMS_SVH
`define SERIAL_MODE_CONTROLLER_PARAMS_SVH

`define SMC_CLK_HZ 50000000
`define SMC_MS_PER_S 1000
`define SMC_CYC_PER_MS (`SMC_CLK_HZ / `SMC_MS_PER_S)
`define SMC_MS_W 16
`define SMC_GUARD_DEFAULT 16'h03E8
`define SMC_ESC_CHAR_DEFAULT 8'h2B
`define SMC_BURST_MS 16'h03E8
`define SMC_BAUD_DEFAULT 4'h3
`define SMC_ESC_COUNT 2'h3
`define SMC_CHAR_O 8'h4F
`define SMC_CHAR_K 8'h4B
`define SMC_CHAR_E 8'h45
`define SMC_CHAR_R 8'h52
`define SMC_CHAR_CR 8'h0D
`define SMC_STATUS_OK 2'h0
`define SMC_STATUS_NO_ADDR 2'h1
`define SMC_STATUS_NO_ROUTE 2'h2

`endif

// file: common/serial_mode_controller_pkg.sv
// Types of the serial operating-mode controller
package serial_mode_controller_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE, MODE_TX, MODE_RX, MODE_SLEEP, MODE_CMD
    } op_mode_type;
    typedef enum logic [2:0] {
        TXS_IDLE, TXS_ADDR, TXS_ROUTE, TXS_SEND, TXS_WAIT_ACK, TXS_DONE
    } tx_state_type;
    typedef enum logic [1:0] {
        ESC_IDLE, ESC_BURST, ESC_POST
    } esc_state_type;
endpackage : serial_mode_controller_pkg

// file: hdl/serial_mode_controller.sv
// Operating-mode sequencer, escape detector and transmit path of the module
//
// Notes on behaviour
// - Transparent mode forwards every serial byte to radio unless in command.
// - Framed mode reports a status per transmission: success or failure cause.
// - Framed receive data carries the originating node address.
// - Idle whenever not sending or receiving; leave only on defined triggers.
// - Idle goes to transmit once buffered serial data is ready.
// - Idle goes to receive on valid radio data; sleep only as end device.
// - Command mode cannot be entered while SPI is the active port.
// - Before sending, resolve network address and route, discovering either.
// - Drop packet if address or route discovery fails; send once routed.
// - Retransmit when no network acknowledgement returns.
// - Duplicate received packets are passed on, never filtered.
// - Valid radio payload goes into the serial transmit buffer; the code drops it in command mode.
// - In command mode serial characters are commands, not payload.
// - Reply OK and CR after entry, after pending serial output drains.
// - Entering command mode starts the command idle timer.
// - Guard time and escape character are software configurable.
// - Baud select defaults to code 3, meaning 9600 bps.
// - Leave command mode on exit command or command idle timeout.
// - Packetize after packetization timeout of silence; zero means at once.
// - Each executed command answers OK on success, ERROR on failure.
`timescale 1ns/100ps
`include "serial_mode_controller_params.svh"

module serial_mode_controller
    import serial_mode_controller_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // Configuration
    input wire logic i_api_mode,
    input wire logic i_spi_active,
    input wire logic i_end_device,
    input wire logic i_sleep_req,
    input wire logic [15:0] i_guard_silence_period,
    input wire logic [7:0] i_escape_sequence_char,
    input wire logic [15:0] i_command_idle_timeout,
    input wire logic [15:0] i_packetization_timeout,
    // Serial receive side
    input wire logic i_ser_valid,
    input wire logic [7:0] i_ser_data,
    input wire logic i_ser_out_busy,
    // Command interpreter
    input wire logic i_cmd_done,
    input wire logic i_cmd_ok,
    input wire logic i_exit_command_op,
    // Network side
    input wire logic i_addr_known,
    input wire logic i_route_known,
    input wire logic i_disc_done,
    input wire logic i_disc_found,
    input wire logic i_net_ack,
    input wire logic i_ack_timeout,
    input wire logic i_rf_valid,
    input wire logic [7:0] i_rf_data,
    input wire logic [15:0] i_rf_src_addr,
    // Mode and status
    output logic [2:0] o_mode,
    output logic [3:0] o_baud_rate_select,
    // Forwarded payload and commands
    output logic o_pay_valid,
    output logic [7:0] o_pay_data,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_data,
    output logic o_packetize,
    // Network requests
    output logic o_addr_disc,
    output logic o_route_disc,
    output logic o_rf_send,
    output logic o_tx_status_valid,
    output logic [1:0] o_tx_status,
    output logic o_drop,
    // Serial transmit buffer
    output logic o_stx_valid,
    output logic [7:0] o_stx_data,
    output logic [15:0] o_stx_src_addr
);

    // ************************************************************
    // Millisecond tick
    // ************************************************************
    logic [15:0] ms_div_q;
    logic ms_tick;
    assign ms_tick = (ms_div_q == 16'(`SMC_CYC_PER_MS - 1));

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ms_div_q <= 16'h0000;
        end else if (ms_tick) begin
            ms_div_q <= 16'h0000;
        end else begin
            ms_div_q <= ms_div_q + 16'h0001;
        end
    end

    // ************************************************************
    // Escape sequence detector
    // ************************************************************
    op_mode_type mode_q;
    esc_state_type esc_q;
    logic [15:0] quiet_ms_q;
    logic [15:0] esc_ms_q;
    logic [1:0] esc_cnt_q;
    logic esc_hit;
    logic cmd_enter;
    logic guard_met;
    logic is_esc;

    assign is_esc = i_ser_valid && (i_ser_data == i_escape_sequence_char);
    assign guard_met = (quiet_ms_q >= i_guard_silence_period);

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            quiet_ms_q <= 16'h0000;
        end else if (i_ser_valid) begin
            quiet_ms_q <= 16'h0000;
        end else if (ms_tick && quiet_ms_q != 16'hFFFF) begin
            quiet_ms_q <= quiet_ms_q + 16'h0001;
        end
    end

    // Any stray byte restarts detection so it stays ordinary payload
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            esc_q <= ESC_IDLE;
            esc_cnt_q <= 2'h0;
            esc_ms_q <= 16'h0000;
        end else begin
            case (esc_q)
                ESC_IDLE: begin
                    if (is_esc && guard_met && mode_q != MODE_CMD
                        && !i_spi_active && !i_api_mode) begin
                        esc_q <= ESC_BURST;
                        esc_cnt_q <= 2'h1;
                        esc_ms_q <= 16'h0000;
                    end
                end
                ESC_BURST: begin
                    if (ms_tick) begin
                        esc_ms_q <= esc_ms_q + 16'h0001;
                    end
                    if (esc_ms_q >= `SMC_BURST_MS) begin
                        esc_q <= ESC_IDLE;
                    end else if (i_ser_valid && !is_esc) begin
                        esc_q <= ESC_IDLE;
                    end else if (is_esc) begin
                        esc_cnt_q <= esc_cnt_q + 2'h1;
                        if (esc_cnt_q + 2'h1 == `SMC_ESC_COUNT) begin
                            esc_q <= ESC_POST;
                        end
                    end
                end
                ESC_POST: begin
                    if (i_ser_valid || i_spi_active) begin
                        esc_q <= ESC_IDLE;
                    end else if (guard_met) begin
                        esc_q <= ESC_IDLE;
                    end
                end
                default: begin
                    esc_q <= ESC_IDLE;
                end
            endcase
        end
    end

    assign esc_hit = (esc_q == ESC_POST) && !i_ser_valid && guard_met
                     && !i_spi_active;

    // ************************************************************
    // Operating mode sequencer
    // ************************************************************
    logic [15:0] silence_ms_q;
    logic have_data_q;
    logic ready_pkt;
    logic tx_busy;
    logic [15:0] cmd_ms_q;
    logic cmd_timeout;

    // Zero timeout packetizes in the cycle after the character arrived
    assign ready_pkt = have_data_q && ((i_packetization_timeout == 16'h0000)
        || (silence_ms_q >= i_packetization_timeout));
    assign cmd_timeout = (cmd_ms_q >= i_command_idle_timeout);
    assign cmd_enter = esc_hit && (mode_q == MODE_IDLE);

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_q <= MODE_IDLE;
        end else begin
            case (mode_q)
                MODE_IDLE: begin
                    if (cmd_enter) begin
                        mode_q <= MODE_CMD;
                    end else if (ready_pkt) begin
                        mode_q <= MODE_TX;
                    end else if (i_rf_valid) begin
                        mode_q <= MODE_RX;
                    end else if (i_sleep_req && i_end_device) begin
                        mode_q <= MODE_SLEEP;
                    end
                end
                MODE_TX: begin
                    if (!tx_busy) begin
                        mode_q <= MODE_IDLE;
                    end
                end
                MODE_RX: begin
                    if (!i_rf_valid) begin
                        mode_q <= MODE_IDLE;
                    end
                end
                MODE_SLEEP: begin
                    if (!i_sleep_req || !i_end_device) begin
                        mode_q <= MODE_IDLE;
                    end
                end
                MODE_CMD: begin
                    if (i_exit_command_op || cmd_timeout) begin
                        mode_q <= MODE_IDLE;
                    end
                end
                default: begin
                    mode_q <= MODE_IDLE;
                end
            endcase
        end
    end

    assign o_mode = mode_q;
    assign o_baud_rate_select = `SMC_BAUD_DEFAULT;

    // Command idle timer restarts on entry and on every successful command
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_ms_q <= 16'h0000;
        end else if (cmd_enter || (i_cmd_done && i_cmd_ok)) begin
            cmd_ms_q <= 16'h0000;
        end else if (mode_q == MODE_CMD && ms_tick && !cmd_timeout) begin
            cmd_ms_q <= cmd_ms_q + 16'h0001;
        end
    end

    // ************************************************************
    // Serial byte routing and packetization
    // ************************************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pay_valid <= 1'b0;
            o_pay_data <= 8'h00;
            o_cmd_valid <= 1'b0;
            o_cmd_data <= 8'h00;
        end else begin
            o_pay_valid <= i_ser_valid && mode_q != MODE_CMD;
            o_cmd_valid <= i_ser_valid && mode_q == MODE_CMD;
            if (i_ser_valid) begin
                o_pay_data <= i_ser_data;
                o_cmd_data <= i_ser_data;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            silence_ms_q <= 16'h0000;
            have_data_q <= 1'b0;
        end else begin
            if (i_ser_valid && mode_q != MODE_CMD) begin
                have_data_q <= 1'b1;
                silence_ms_q <= 16'h0000;
            end else if (mode_q == MODE_IDLE && ready_pkt && !cmd_enter) begin
                have_data_q <= 1'b0;
            end else if (ms_tick && silence_ms_q != 16'hFFFF) begin
                silence_ms_q <= silence_ms_q + 16'h0001;
            end
        end
    end

    assign o_packetize = (mode_q == MODE_IDLE) && ready_pkt && !cmd_enter;

    // ************************************************************
    // Transmit path: address, route, send, acknowledge
    // ************************************************************
    tx_state_type tx_q;
    assign tx_busy = (tx_q != TXS_IDLE);

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_q <= TXS_IDLE;
            o_tx_status <= `SMC_STATUS_OK;
            o_tx_status_valid <= 1'b0;
            o_drop <= 1'b0;
        end else begin
            o_tx_status_valid <= 1'b0;
            o_drop <= 1'b0;
            case (tx_q)
                TXS_IDLE: begin
                    if (o_packetize) begin
                        tx_q <= TXS_ADDR;
                    end
                end
                TXS_ADDR: begin
                    if (i_addr_known || (i_disc_done && i_disc_found)) begin
                        tx_q <= TXS_ROUTE;
                    end else if (i_disc_done && !i_disc_found) begin
                        o_drop <= 1'b1;
                        o_tx_status <= `SMC_STATUS_NO_ADDR;
                        o_tx_status_valid <= i_api_mode;
                        tx_q <= TXS_IDLE;
                    end
                end
                TXS_ROUTE: begin
                    if (i_route_known || (i_disc_done && i_disc_found)) begin
                        tx_q <= TXS_SEND;
                    end else if (i_disc_done && !i_disc_found) begin
                        o_drop <= 1'b1;
                        o_tx_status <= `SMC_STATUS_NO_ROUTE;
                        o_tx_status_valid <= i_api_mode;
                        tx_q <= TXS_IDLE;
                    end
                end
                TXS_SEND: begin
                    tx_q <= TXS_WAIT_ACK;
                end
                TXS_WAIT_ACK: begin
                    if (i_net_ack) begin
                        o_tx_status <= `SMC_STATUS_OK;
                        o_tx_status_valid <= i_api_mode;
                        tx_q <= TXS_IDLE;
                    end else if (i_ack_timeout) begin
                        tx_q <= TXS_SEND;
                    end
                end
                default: begin
                    tx_q <= TXS_IDLE;
                end
            endcase
        end
    end

    assign o_addr_disc = (tx_q == TXS_ADDR) && !i_addr_known;
    assign o_route_disc = (tx_q == TXS_ROUTE) && !i_route_known;
    assign o_rf_send = (tx_q == TXS_SEND);

    // ************************************************************
    // Receive path and command replies
    // ************************************************************
    logic [2:0] rep_idx_q;
    logic rep_ok_q;
    logic rep_pend_q;
    logic [7:0] rep_char;

    always_comb begin
        rep_char = `SMC_CHAR_CR;
        case ({rep_ok_q, rep_idx_q})
            4'h8: rep_char = `SMC_CHAR_O;
            4'h9: rep_char = `SMC_CHAR_K;
            4'h0: rep_char = `SMC_CHAR_E;
            4'h1: rep_char = `SMC_CHAR_R;
            4'h2: rep_char = `SMC_CHAR_R;
            4'h3: rep_char = `SMC_CHAR_O;
            4'h4: rep_char = `SMC_CHAR_R;
            default: rep_char = `SMC_CHAR_CR;
        endcase
    end

    // Reply waits for pending serial output; radio bytes pass duplicates
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rep_pend_q <= 1'b0;
            rep_ok_q <= 1'b1;
            rep_idx_q <= 3'h0;
            o_stx_valid <= 1'b0;
            o_stx_data <= 8'h00;
            o_stx_src_addr <= 16'h0000;
        end else begin
            o_stx_valid <= 1'b0;
            if (cmd_enter || (i_cmd_done && mode_q == MODE_CMD)) begin
                rep_pend_q <= 1'b1;
                rep_ok_q <= cmd_enter || i_cmd_ok;
                rep_idx_q <= 3'h0;
            end else if (rep_pend_q && !i_ser_out_busy && !i_rf_valid) begin
                o_stx_valid <= 1'b1;
                o_stx_data <= rep_char;
                rep_idx_q <= rep_idx_q + 3'h1;
                if (rep_char == `SMC_CHAR_CR) begin
                    rep_pend_q <= 1'b0;
                end
            end else if (i_rf_valid && mode_q != MODE_CMD) begin
                o_stx_valid <= 1'b1;
                o_stx_data <= i_rf_data;
                o_stx_src_addr <= i_rf_src_addr;
            end
        end
    end

endmodule : serial_mode_controller

// file: tb/serial_mode_controller_assertions.sv
// Port-level checker of the serial operating-mode controller
`timescale 1ns/100ps
module serial_mode_controller_assertions
    import serial_mode_controller_pkg::*;
(
    // Clock, reset and configuration
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_api_mode,
    input wire logic i_spi_active,
    input wire logic i_end_device,
    input wire logic i_sleep_req,
    // Stimulus
    input wire logic i_ser_valid,
    input wire logic [7:0] i_ser_data,
    input wire logic i_ser_out_busy,
    input wire logic i_exit_command_op,
    input wire logic i_disc_done,
    input wire logic i_disc_found,
    input wire logic i_rf_valid,
    input wire logic [7:0] i_rf_data,
    input wire logic [15:0] i_rf_src_addr,
    // Outputs watched
    input wire logic [2:0] o_mode,
    input wire logic [3:0] o_baud_rate_select,
    input wire logic o_pay_valid,
    input wire logic [7:0] o_pay_data,
    input wire logic o_cmd_valid,
    input wire logic o_addr_disc,
    input wire logic o_route_disc,
    input wire logic o_rf_send,
    input wire logic o_tx_status_valid,
    input wire logic [1:0] o_tx_status,
    input wire logic o_drop,
    input wire logic o_stx_valid,
    input wire logic [7:0] o_stx_data,
    input wire logic [15:0] o_stx_src_addr
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    property p_pay; i_ser_valid && o_mode != MODE_CMD |=>
        o_pay_valid && o_pay_data == $past(i_ser_data); endproperty
    a_pay: assert property (p_pay) else $error("byte not forwarded");
    property p_cmd; i_ser_valid && o_mode == MODE_CMD |=>
        o_cmd_valid && !o_pay_valid; endproperty
    a_cmd: assert property (p_cmd) else $error("command sent as data");
    property p_baud; o_baud_rate_select == 4'h3; endproperty
    a_baud: assert property (p_baud) else $error("baud code wrong");
    property p_spi; i_spi_active && o_mode != MODE_CMD |=>
        o_mode != MODE_CMD; endproperty
    a_spi: assert property (p_spi) else $error("command over spi");
    property p_rx; o_mode == MODE_RX && i_rf_valid |=> o_stx_valid &&
        o_stx_data == $past(i_rf_data) &&
        o_stx_src_addr == $past(i_rf_src_addr); endproperty
    a_rx: assert property (p_rx) else $error("radio byte lost");
    property p_idle_rx; o_mode == MODE_IDLE && i_rf_valid && !i_sleep_req &&
        !i_ser_valid |=> o_mode == MODE_RX; endproperty
    a_idle_rx: assert property (p_idle_rx) else $error("no rx mode");
    property p_sleep; o_mode == MODE_IDLE && !i_end_device |=>
        o_mode != MODE_SLEEP; endproperty
    a_sleep: assert property (p_sleep) else $error("router slept");
    property p_send; o_rf_send |-> !o_addr_disc && !o_route_disc; endproperty
    a_send: assert property (p_send) else $error("sent unresolved");
    property p_drop; o_drop |-> $past(i_disc_done) && !$past(i_disc_found);
    endproperty
    a_drop: assert property (p_drop) else $error("stray discard");
    property p_status; o_tx_status_valid |-> $past(i_api_mode) &&
        o_tx_status != 2'h3; endproperty
    a_status: assert property (p_status) else $error("bad status");
    property p_exit; o_mode == MODE_CMD && i_exit_command_op |=>
        o_mode == MODE_IDLE; endproperty
    a_exit: assert property (p_exit) else $error("exit ignored");
    property p_reply; o_stx_valid && !$past(i_rf_valid) |->
        !$past(i_ser_out_busy); endproperty
    a_reply: assert property (p_reply) else $error("reply not held");
endmodule : serial_mode_controller_assertions

bind serial_mode_controller serial_mode_controller_assertions chk_i (
    .i_ref_clk, .i_resetn, .i_api_mode, .i_spi_active, .i_end_device,
    .i_sleep_req, .i_ser_valid, .i_ser_data, .i_ser_out_busy,
    .i_exit_command_op, .i_disc_done, .i_disc_found, .i_rf_valid,
    .i_rf_data, .i_rf_src_addr, .o_mode, .o_baud_rate_select, .o_pay_valid,
    .o_pay_data, .o_cmd_valid, .o_addr_disc, .o_route_disc, .o_rf_send,
    .o_tx_status_valid, .o_tx_status, .o_drop, .o_stx_valid, .o_stx_data,
    .o_stx_src_addr
);

// file: tb/serial_host_model.sv
// Host controller model on the serial port
`timescale 1ns/100ps
module serial_host_model (
    // Clock
    input wire logic i_ref_clk,
    // Serial link
    output logic o_ser_valid,
    output logic [7:0] o_ser_data,
    input wire logic i_stx_valid,
    input wire logic [7:0] i_stx_data
);
    logic [7:0] rx_q[$];
    initial begin
        o_ser_valid = 1'b0;
        o_ser_data = 8'h00;
    end
    // One byte; data inverted once released so no stale value lingers
    task automatic send(input logic [7:0] b);
        @(posedge i_ref_clk);
        #1;
        o_ser_valid = 1'b1;
        o_ser_data = b;
        @(posedge i_ref_clk);
        #1;
        o_ser_valid = 1'b0;
        o_ser_data = ~b;
    endtask : send
    // Keeps repeats too; duplicates are the host's problem
    always @(posedge i_ref_clk) begin
        if (i_stx_valid === 1'b1) begin
            rx_q.push_back(i_stx_data);
        end
    end
endmodule : serial_host_model

// file: tb/serial_mode_controller_tb.sv
// Self-checking bench of the serial operating-mode controller
`timescale 1ns/100ps
module serial_mode_controller_tb import serial_mode_controller_pkg::*;;
    logic i_ref_clk, i_resetn, i_api_mode, i_spi_active, i_end_device;
    logic i_sleep_req, i_ser_valid, i_ser_out_busy, i_cmd_done, i_cmd_ok;
    logic i_exit_command_op, i_addr_known, i_route_known, i_disc_done;
    logic i_disc_found, i_net_ack, i_ack_timeout, i_rf_valid;
    logic [15:0] i_guard_silence_period, i_command_idle_timeout;
    logic [15:0] i_packetization_timeout, i_rf_src_addr, o_stx_src_addr;
    logic [7:0] i_escape_sequence_char, i_ser_data, i_rf_data;
    logic [7:0] o_pay_data, o_cmd_data, o_stx_data;
    logic [2:0] o_mode;
    logic [3:0] o_baud_rate_select;
    logic [1:0] o_tx_status;
    logic o_pay_valid, o_cmd_valid, o_packetize, o_addr_disc, o_route_disc;
    logic o_rf_send, o_tx_status_valid, o_drop, o_stx_valid;
    int fails = 0;
    int checks_done = 0;

    serial_mode_controller serial_mode_controller_i (
        .i_ref_clk, .i_resetn, .i_api_mode, .i_spi_active, .i_end_device,
        .i_sleep_req, .i_guard_silence_period, .i_escape_sequence_char,
        .i_command_idle_timeout, .i_packetization_timeout, .i_ser_valid,
        .i_ser_data, .i_ser_out_busy, .i_cmd_done, .i_cmd_ok,
        .i_exit_command_op, .i_addr_known, .i_route_known, .i_disc_done,
        .i_disc_found, .i_net_ack, .i_ack_timeout, .i_rf_valid, .i_rf_data,
        .i_rf_src_addr, .o_mode, .o_baud_rate_select, .o_pay_valid,
        .o_pay_data, .o_cmd_valid, .o_cmd_data, .o_packetize, .o_addr_disc,
        .o_route_disc, .o_rf_send, .o_tx_status_valid, .o_tx_status, .o_drop,
        .o_stx_valid, .o_stx_data, .o_stx_src_addr);
    serial_host_model serial_host_model_i (.i_ref_clk,
        .o_ser_valid(i_ser_valid), .o_ser_data(i_ser_data),
        .i_stx_valid(o_stx_valid), .i_stx_data(o_stx_data));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : cyc
    function automatic logic pick(input int s);
        case (s)
            0: pick = o_addr_disc;
            1: pick = o_route_disc;
            2: pick = o_rf_send;
            3: pick = o_drop;
            4: pick = o_tx_status_valid;
            5: pick = (o_mode === MODE_CMD);
            default: pick = (o_mode === MODE_IDLE);
        endcase
    endfunction : pick
    // Bounded wait for an output, sampled once per cycle
    task automatic wait_on(input int s, input int lim);
        int n;
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        check(16'(n < lim), 16'h0001);
    endtask : wait_on
    task automatic pulse(input int s);
        cyc(0);
        @(posedge i_ref_clk);
        #1;
        case (s)
            0: i_disc_done = 1'b1;
            1: i_net_ack = 1'b1;
            2: i_ack_timeout = 1'b1;
            3: i_cmd_done = 1'b1;
            default: i_exit_command_op = 1'b1;
        endcase
        cyc(1);
        {i_disc_done, i_net_ack, i_ack_timeout, i_cmd_done} = 4'h0;
        i_exit_command_op = 1'b0;
    endtask : pulse
    task automatic expect_text(input string s);
        int k;
        cyc(14);
        check(16'(serial_host_model_i.rx_q.size()), 16'(s.len()));
        for (k = 0; k < serial_host_model_i.rx_q.size(); k++) begin
            check({8'h00, serial_host_model_i.rx_q[k]}, {8'h00, s[k]});
        end
        serial_host_model_i.rx_q.delete();
    endtask : expect_text
    task automatic send_pay(input logic [7:0] b);
        serial_host_model_i.send(b);
        check({15'h0000, o_pay_valid}, 16'h0001);
        check({8'h00, o_pay_data}, {8'h00, b});
    endtask : send_pay

    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // Escape needs two guard spans of 1 ms each
    initial begin
        #2200000;
        fails++;
        complete_run();
    end
    initial begin
        {i_resetn, i_end_device, i_sleep_req, i_ser_out_busy} = 4'h0;
        {i_cmd_done, i_cmd_ok, i_exit_command_op, i_addr_known} = 4'h0;
        {i_route_known, i_disc_done, i_disc_found, i_net_ack} = 4'h0;
        {i_ack_timeout, i_rf_valid, i_api_mode, i_spi_active} = 4'h3;
        i_guard_silence_period = 16'h0001;
        i_escape_sequence_char = 8'h21;
        i_command_idle_timeout = 16'h00FF;
        i_packetization_timeout = 16'h0000;
        i_rf_data = 8'h5A;
        i_rf_src_addr = 16'h1234;
        cyc(12);
        i_resetn = 1'b1;
        check({12'h000, o_baud_rate_select}, 16'h0003);
        check({13'h0000, o_mode}, 16'(MODE_IDLE));
        // Framed over SPI: address discovery fails
        send_pay(8'h41);
        check({15'h0000, o_packetize}, 16'h0001);
        wait_on(0, 10);
        check({13'h0000, o_mode}, 16'(MODE_TX));
        pulse(0);
        wait_on(3, 4);
        check({14'h0000, o_tx_status}, 16'h0001);
        wait_on(7, 10);
        // Route found, one missing ack, then delivered
        {i_addr_known, i_disc_found} = 2'h3;
        send_pay(8'h42);
        wait_on(1, 10);
        check({15'h0000, o_addr_disc}, 16'h0000);
        pulse(0);
        wait_on(2, 4);
        pulse(2);
        wait_on(2, 4);
        pulse(1);
        wait_on(4, 4);
        check({14'h0000, o_tx_status}, 16'h0000);
        wait_on(7, 10);
        // Same radio byte twice
        i_rf_valid = 1'b1;
        cyc(1);
        check({13'h0000, o_mode}, 16'(MODE_RX));
        check(o_stx_src_addr, 16'h1234);
        cyc(1);
        i_rf_valid = 1'b0;
        expect_text("ZZ");
        // Sleep only as end device
        i_sleep_req = 1'b1;
        cyc(3);
        check({13'h0000, o_mode}, 16'(MODE_IDLE));
        i_end_device = 1'b1;
        cyc(3);
        check({13'h0000, o_mode}, 16'(MODE_SLEEP));
        i_sleep_req = 1'b0;
        wait_on(7, 10);
        // Escape over UART with a non-default character, output busy
        {i_api_mode, i_spi_active, i_ser_out_busy} = 3'h1;
        i_packetization_timeout = 16'h0002;
        cyc(55000);
        repeat (3) send_pay(8'h21);
        wait_on(5, 60000);
        cyc(5);
        check(16'(serial_host_model_i.rx_q.size()), 16'h0000);
        i_ser_out_busy = 1'b0;
        expect_text("OK\015");
        serial_host_model_i.send(8'h61);
        check({15'h0000, o_cmd_valid}, 16'h0001);
        check({7'h00, o_pay_valid, o_cmd_data}, 16'h0061);
        pulse(3);
        expect_text("ERROR\015");
        i_cmd_ok = 1'b1;
        pulse(3);
        expect_text("OK\015");
        pulse(4);
        check({13'h0000, o_mode}, 16'(MODE_IDLE));
        send_pay(8'h33);
        complete_run();
    end
endmodule : serial_mode_controller_tb
